/* File: design/phb_host_port.sv */
/*
 * Host bus side of a program memory and two-port parallel I/O device:
 * address latch, memory read, port read and write, wait output.
 * Program memory is filled through a same-clock load port.
 * Assumes pins arrive asynchronously to sys_clk and that the outside
 * wire resolves bus and wait levels from the output enables.
 */
`timescale 1ns/10ps
module phb_host_port
(
    input  wire logic                     sys_clk,
    input  wire logic                     rstn,
    input  wire phb_pkg::phb_pins_s       pins,
    input  wire phb_pkg::phb_load_s       load,
    output logic [phb_pkg::DATA_W-1:0]    bus_out,
    output logic                          bus_oe,
    output logic                          ready_out,
    output logic                          ready_oe,
    output logic [phb_pkg::DATA_W-1:0]    port_a,
    output logic [phb_pkg::DATA_W-1:0]    port_b
);
    import phb_pkg::*;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    // Three stages; a bit moves only when stages two and three agree,
    // which costs a cycle but rejects single-sample glitches.
    logic [SYNC_W-1:0] sync1;
    logic [SYNC_W-1:0] sync2;
    logic [SYNC_W-1:0] sync3;
    logic [SYNC_W-1:0] filt;
    logic [SYNC_W-1:0] next_sync1;
    logic [SYNC_W-1:0] next_sync2;
    logic [SYNC_W-1:0] next_sync3;
    logic [SYNC_W-1:0] next_filt;
    phb_pins_s         pin;

    always_comb begin
        next_sync1 = pins;
        next_sync2 = sync1;
        next_sync3 = sync2;
        next_filt  = (sync2 & ~(sync2 ^ sync3)) | (filt & (sync2 ^ sync3));
        pin        = phb_pins_s'(filt);
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            sync1 <= PIN_RESET;
            sync2 <= PIN_RESET;
            sync3 <= PIN_RESET;
            filt  <= PIN_RESET;
        end else begin
            sync1 <= next_sync1;
            sync2 <= next_sync2;
            sync3 <= next_sync3;
            filt  <= next_filt;
        end
    end

    // ------------------------------------------------------------
    // Address latches
    // ------------------------------------------------------------
    phb_latch_s lat;
    phb_latch_s next_lat;
    logic       clk_prev;
    logic       next_clk_prev;

    always_comb begin
        next_lat      = lat;
        next_clk_prev = pin.dev_clk;
        // Transparent while strobe high, so the value held is the one at its fall
        if (pin.ale) begin
            next_lat.ce_n          = pin.ce_n;
            next_lat.ce            = pin.ce;
            next_lat.io_mem_sel    = pin.io_mem_sel;
            next_lat.high_mem_addr = pin.high_mem_addr;
            next_lat.low_addr      = pin.muxed_addr_data_bus;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            lat      <= '0;
            clk_prev <= 1'b0;
        end else begin
            lat      <= next_lat;
            clk_prev <= next_clk_prev;
        end
    end

    // ------------------------------------------------------------
    // Program memory
    // ------------------------------------------------------------
    // Flip-flop storage, loaded through the load port; no reset so the
    // array stays plain storage.
    logic [DATA_W-1:0] mem [MEM_DEPTH];

    always_ff @(posedge sys_clk) begin
        if (load.we) begin
            mem[load.addr] <= load.data;
        end
    end

    // ------------------------------------------------------------
    // Select and source decode
    // ------------------------------------------------------------
    logic                  lat_active;
    logic                  live_active;
    logic                  rd_any;
    logic                  from_port;
    logic [MEM_ADDR_W-1:0] mem_addr;
    logic [DATA_W-1:0]     port_val;

    always_comb begin
        lat_active  = !lat.ce_n && lat.ce;
        live_active = !pin.ce_n && pin.ce;
        rd_any      = !pin.rd_n || !pin.port_read_strobe_n;
        // Port read strobe overrides the latched select
        from_port   = lat.io_mem_sel || !pin.port_read_strobe_n;
        mem_addr    = {lat.high_mem_addr, lat.low_addr};
        port_val    = lat.low_addr[PORT_SEL_BIT] ? port_b : port_a;
    end

    // ------------------------------------------------------------
    // Bus drivers
    // ------------------------------------------------------------
    logic [DATA_W-1:0] next_bus_out;
    logic              next_bus_oe;

    always_comb begin
        next_bus_oe  = lat_active && rd_any;
        next_bus_out = from_port ? port_val : mem[mem_addr];
        // Idle byte while off, so no stale data sits on the outputs
        if (!next_bus_oe) begin
            next_bus_out = BUS_IDLE;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            bus_out <= BUS_IDLE;
            bus_oe  <= 1'b0;
        end else begin
            bus_out <= next_bus_out;
            bus_oe  <= next_bus_oe;
        end
    end

    // ------------------------------------------------------------
    // Port output latches
    // ------------------------------------------------------------
    logic [DATA_W-1:0] next_port_a;
    logic [DATA_W-1:0] next_port_b;

    always_comb begin
        next_port_a = port_a;
        next_port_b = port_b;
        // Memory/IO select plays no part in a port write
        if (lat_active && !pin.port_write_strobe_n) begin
            if (lat.low_addr[PORT_SEL_BIT]) begin
                next_port_b = pin.muxed_addr_data_bus;
            end else begin
                next_port_a = pin.muxed_addr_data_bus;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            port_a <= PORT_RESET;
            port_b <= PORT_RESET;
        end else begin
            port_a <= next_port_a;
            port_b <= next_port_b;
        end
    end

    // ------------------------------------------------------------
    // Wait output
    // ------------------------------------------------------------
    // Wait stays driven while strobe and select hold, even across clock
    // pin rises; a set and a release in one cycle leave it set.
    logic next_ready_out;
    logic next_ready_oe;

    always_comb begin
        next_ready_out = 1'b0;
        // Held low through the strobe; released by a rise of the device clock pin
        if (live_active && pin.ale) begin
            next_ready_oe = 1'b1;
        end else if (pin.dev_clk && !clk_prev) begin
            next_ready_oe = 1'b0;
        end else begin
            next_ready_oe = ready_oe;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            ready_out <= 1'b0;
            ready_oe  <= 1'b0;
        end else begin
            ready_out <= next_ready_out;
            ready_oe  <= next_ready_oe;
        end
    end

endmodule

/* File: design/phb_pkg.sv */
/*
 * Shared types and constants for the program memory and parallel port
 * host bus interface.
 * Assumes a single system clock; every pin input is asynchronous to it.
 */
package phb_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int unsigned DATA_W    = 8;
    localparam int unsigned LOW_ADDR_W = 8;
    localparam int unsigned HIGH_ADDR_W = 3;
    localparam int unsigned MEM_ADDR_W = LOW_ADDR_W + HIGH_ADDR_W;
    localparam int unsigned MEM_DEPTH  = 2048;
    localparam int unsigned SYNC_W     = 19;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int unsigned PORT_SEL_BIT = 0;
    localparam logic [DATA_W-1:0] PORT_RESET = 8'h00;
    localparam logic [DATA_W-1:0] BUS_IDLE   = 8'h00;
    localparam logic [SYNC_W-1:0] PIN_RESET  = 19'h27000;

    // Pin bundle as seen at the package pins
    typedef struct packed {
        logic                   ale;
        logic                   ce_n;
        logic                   ce;
        logic                   io_mem_sel;
        logic                   rd_n;
        logic                   port_read_strobe_n;
        logic                   port_write_strobe_n;
        logic                   dev_clk;
        logic [HIGH_ADDR_W-1:0] high_mem_addr;
        logic [DATA_W-1:0]      muxed_addr_data_bus;
    } phb_pins_s;

    // Contents of the address latches
    typedef struct packed {
        logic                   ce_n;
        logic                   ce;
        logic                   io_mem_sel;
        logic [HIGH_ADDR_W-1:0] high_mem_addr;
        logic [LOW_ADDR_W-1:0]  low_addr;
    } phb_latch_s;

    // Memory load port, used in place of the programming procedure
    typedef struct packed {
        logic                  we;
        logic [MEM_ADDR_W-1:0] addr;
        logic [DATA_W-1:0]     data;
    } phb_load_s;

endpackage

/* File: verification/phb_host_model.sv */
/* Host model driving the pins through bus cycles; assumes the bench calls cyc. */
`timescale 1ns/10ps
module phb_host_model (
    input  wire logic          sys_clk,
    input  wire logic [7:0]    bus_out,
    input  wire logic          bus_oe,
    output phb_pkg::phb_pins_s pins
);
    import phb_pkg::*;
    phb_pins_s drv = '{ce_n: 1'b1, rd_n: 1'b1, port_read_strobe_n: 1'b1, port_write_strobe_n: 1'b1, default: '0};
    logic      hen = 1'b1;
    // A released bus shows the inverse, so a stale byte never passes as data
    always_comb begin
        pins = drv;
        if (bus_oe) pins.muxed_addr_data_bus = bus_out;
        else if (!hen) pins.muxed_addr_data_bus = ~drv.muxed_addr_data_bus;
    end
    // Sel is ce_n, ce, io_mem_sel; k 0 read, 1 port read, 2 port write
    task automatic cyc(input logic [2:0] sel, input logic [10:0] a, input int k, input logic [7:0] d);
        @(posedge sys_clk);
        drv.ale <= 1'b1;
        {drv.ce_n, drv.ce, drv.io_mem_sel, drv.high_mem_addr, drv.muxed_addr_data_bus} <= {sel, a};
        hen <= 1'b1;
        repeat (8) @(posedge sys_clk);
        drv.ale <= 1'b0;
        repeat (5) @(posedge sys_clk);
        {drv.dev_clk, drv.rd_n, drv.port_read_strobe_n, drv.port_write_strobe_n} <= {1'b1, k != 0, k != 1, k != 2};
        drv.muxed_addr_data_bus <= d;
        hen <= (k == 2);
        repeat (8) @(posedge sys_clk);
        {drv.dev_clk, drv.rd_n, drv.port_read_strobe_n, drv.port_write_strobe_n} <= 4'h7;
        repeat (8) @(posedge sys_clk);
    endtask
endmodule

/* File: verification/phb_host_port_sva.sv */
/* Checker on the host port outputs; assumes each pin step is held several clocks. */
`timescale 1ns/10ps
module phb_host_port_sva (
    input wire logic               sys_clk,
    input wire logic               rstn,
    input wire phb_pkg::phb_pins_s pins,
    input wire logic [7:0]         bus_out,
    input wire logic               bus_oe,
    input wire logic               ready_out,
    input wire logic               ready_oe,
    input wire logic [7:0]         port_a,
    input wire logic [7:0]         port_b
);
    import phb_pkg::*;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    // Counts allow for the pin filter plus the output register
    wire act = !pins.ce_n && pins.ce;
    sequence s_sel; (pins.ale && act)[*5] ##1 (!pins.ale && act)[*5]; endsequence
    sequence s_unsel; (pins.ale && !act)[*5] ##1 !pins.ale[*5]; endsequence
    sequence s_rise; (!pins.ale && !pins.dev_clk)[*4] ##1 (!pins.ale && pins.dev_clk)[*7]; endsequence
    a_rd_drive: assert property (s_sel ##1 (!pins.ale && !pins.rd_n)[*7] |-> bus_oe)
        else $error("read not driven");
    a_port_rd_drive: assert property (s_sel ##1 (!pins.ale && !pins.port_read_strobe_n)[*7] |-> bus_oe)
        else $error("port read not driven");
    a_unsel_off: assert property (s_unsel ##1 !pins.ale[*7] |-> !bus_oe)
        else $error("unselected drive");
    a_bus_off: assert property ((pins.rd_n && pins.port_read_strobe_n)[*7] |-> !bus_oe)
        else $error("idle drive");
    a_bus_zero: assert property (!bus_oe |-> bus_out == BUS_IDLE)
        else $error("data while off");
    a_wait_set: assert property ((pins.ale && act)[*7] |-> ready_oe && !ready_out)
        else $error("wait not low");
    a_wait_free: assert property (s_rise |-> !ready_oe)
        else $error("wait held");
    a_one_port: assert property (!($changed(port_a) && $changed(port_b)))
        else $error("two ports written");
endmodule

/* File: verification/phb_host_port_tb.sv */
/* Bench for the host port; assumes the host model and the checker bound below. */
`timescale 1ns/10ps
module phb_host_port_tb;
    import phb_pkg::*;
    logic        sys_clk = 1'b0, rstn = 1'b0, bus_oe, oe_q, ready_oe, ready_out, wait_q;
    phb_pins_s   pins;
    phb_load_s   ld = '0;
    logic [7:0]  bus_out, port_a, port_b, pa = 8'h00, pb = 8'h00, d, q [$];
    logic [10:0] ma [4] = '{11'h000, 11'h7ff, 11'h2a5, 11'h400};
    int          n_fail = 0, comparisons = 0, n_wait = 0, i, seed = 32'ha2c1a707;
    always #2 sys_clk = ~sys_clk;
    phb_host_port uut (.sys_clk(sys_clk), .rstn(rstn), .pins(pins), .load(ld), .bus_out(bus_out), .bus_oe(bus_oe),
                       .ready_out(ready_out), .ready_oe(ready_oe), .port_a(port_a), .port_b(port_b));
    phb_host_model host (.sys_clk(sys_clk), .bus_out(bus_out), .bus_oe(bus_oe), .pins(pins));
    task automatic chk(input string nm, input logic [15:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // A new drive takes the oldest note; with none queued it must not occur
    // Outputs are looked at on the falling edge, clear of their launch
    always @(negedge sys_clk) begin
        oe_q   <= bus_oe;
        wait_q <= ready_oe;
        if (ready_oe === 1'b1 && wait_q !== 1'b1) n_wait++;
        if (bus_oe === 1'b1 && oe_q !== 1'b1) begin
            chk("bus", {8'h00, bus_out}, {8'h00, q.size() ? q.pop_front() : 8'hxx});
        end
    end
    initial begin
        #20000 n_fail++;
        stop_test();
    end
    initial begin
        repeat (3) @(posedge sys_clk);
        rstn <= 1'b1;
        for (i = 0; i < 4; i++) begin
            d = 8'($random(seed));
            ld <= '{1'b1, ma[i], d};
            @(posedge sys_clk);
            ld <= '0;
            q.push_back(d);
            host.cyc(3'b010, ma[i], 0, 8'h00);
            chk("wait released", {15'h0000, ready_oe}, 16'h0000);
        end
        $display("memory test done");
        for (i = 0; i < 4; i++) begin
            d = 8'($random(seed));
            if (i[0]) pb = d;
            else pa = d;
            host.cyc({2'b01, ~i[0]}, {10'($random(seed)), i[0]}, 2, d);
            chk("ports", {port_a, port_b}, {pa, pb});
        end
        q = '{pa, pb};
        host.cyc(3'b011, 11'h000, 0, 8'h00);
        host.cyc(3'b010, 11'h001, 1, 8'h00);
        $display("port test done");
        host.cyc(3'b110, 11'h001, 0, 8'h00);
        host.cyc(3'b000, 11'h000, 2, ~pa);
        chk("ports", {port_a, port_b}, {pa, pb});
        // Ten selected cycles pull wait low; the two unselected ones must not
        chk("wait pulls", 16'(n_wait), 16'h000a);
        chk("wait level", {15'h0000, ready_out}, 16'h0000);
        $display("unselected test done");
        stop_test();
    end
endmodule
bind phb_host_port phb_host_port_sva u_sva (.sys_clk(sys_clk), .rstn(rstn), .pins(pins), .bus_out(bus_out),
    .bus_oe(bus_oe), .ready_out(ready_out), .ready_oe(ready_oe), .port_a(port_a), .port_b(port_b));
